/* hdl/vproc_control_regs.sv */
// Control and status register bank at offsets 00h to 06h.
`timescale 1ns/1ps
`default_nettype none
`include "vproc_regs_cfg.svh"
module vproc_control_regs
(
  // Clock, enable and reset.
  input wire logic mclk,
  input wire logic clk_en,
  input wire logic rst_n,
  // Register access from the primary control port.
  input wire vproc_regs_pkg::reg_req_s req,
  output logic [7:0] rdata,
  output logic rdata_valid,
  // Events from the secondary master, boot engine and WHITE_BALANCE_START engine.
  input wire logic no_ack_event,
  input wire logic sec_cmd_issued,
  input wire logic secondary_master_busy,
  input wire logic boot_load_active,
  input wire logic awb_done,
  // Asynchronous pins.
  input wire logic even_field_pin,
  input wire logic hiz_strap_pin,
  input wire logic scaler_strap_pin,
  input wire logic four_byte_strap_pin,
  input wire logic output_enable_pin,
  // Controls toward the datapath and pins.
  output logic soft_reset_pulse,
  output logic pll_clock_out_enable,
  output logic field_pin_direction,
  output logic chroma_phase_clock_select,
  output logic [4:0] luma_gain_value,
  output vproc_regs_pkg::scaler_cfg_s scaler_cfg,
  output logic scaler_5to4_select,
  output logic awb_start_pulse,
  output vproc_regs_pkg::feature_cfg_s feature_cfg,
  output vproc_regs_pkg::oper_cfg_s oper_cfg,
  output logic digital_outputs_enable
);
  import vproc_regs_pkg::*;

  // Reset release: pin reset or self-clearing soft reset.
  logic [1:0] rst_sync_q;
  logic soft_rst_q;
  logic srst_n;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign srst_n = rst_sync_q[1];

  // Pin synchronisers: three stages, a change counts when 2nd and 3rd agree.
  logic [4:0] pin_raw;
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  logic [4:0] pin_s3_q;
  logic [4:0] pin_q;
  assign pin_raw = {output_enable_pin, four_byte_strap_pin,
                    scaler_strap_pin, hiz_strap_pin, even_field_pin};
  always_ff @(posedge mclk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      pin_s1_q <= 5'h00;
      pin_s2_q <= 5'h00;
      pin_s3_q <= 5'h00;
    end
    else if (clk_en)
    begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_pin
      always_ff @(posedge mclk or negedge srst_n)
      begin
        if (!srst_n)
          pin_q[gi] <= 1'b0;
        else if (clk_en && (pin_s2_q[gi] == pin_s3_q[gi]))
          pin_q[gi] <= pin_s3_q[gi];
      end
    end
  endgenerate

  // Register storage; the soft reset clears it through the internal reset.
  logic [7:0] pin_io_q;
  logic [7:0] gain_q;
  logic [7:0] scaler_q;
  logic [7:0] feature_q;
  logic [7:0] oper_q;
  logic no_ack_q;
  awb_state_e awb_q;
  awb_state_e awb_d;
  logic core_rst_n;
  assign core_rst_n = srst_n & ~soft_rst_q;

  // Writes are dropped while the boot download owns the bank.
  logic wr_ok;
  logic wr_reset;
  logic wr_status;
  logic wr_pin;
  logic wr_gain;
  logic wr_scaler;
  logic wr_feature;
  logic wr_oper;
  logic awb_go;
  assign wr_ok = clk_en & req.wr & ~boot_load_active;
  assign wr_reset = wr_ok & (req.addr == `OFS_MASTER_RESET);
  assign wr_status = wr_ok & (req.addr == `OFS_DEVICE_STATUS);
  assign wr_pin = wr_ok & (req.addr == `OFS_PIN_IO_CONTROL);
  assign wr_gain = wr_ok & (req.addr == `OFS_LUMA_GAIN);
  assign wr_scaler = wr_ok & (req.addr == `OFS_SCALER_CONTROL);
  assign wr_feature = wr_ok & (req.addr == `OFS_FEATURE_CONTROL);
  assign wr_oper = wr_ok & (req.addr == `OFS_OPERATIONAL_CONTROL);
  assign awb_go = wr_feature & req.wdata[`BIT_AWB_START];

  // The soft reset is a one-cycle pulse; it releases itself next cycle.
  always_ff @(posedge mclk or negedge srst_n)
  begin
    if (!srst_n)
      soft_rst_q <= 1'b0;
    else if (clk_en)
      soft_rst_q <= wr_reset & req.wdata[`BIT_FULL_RESET] & ~soft_rst_q;
  end

  // Reserved bits are masked on the way in, so they always read as zero.
  always_ff @(posedge mclk or negedge core_rst_n)
  begin
    if (!core_rst_n)
      pin_io_q <= `ZERO_BYTE;
    else if (wr_pin)
      pin_io_q <= req.wdata & `PIN_IO_MASK;
  end

  always_ff @(posedge mclk or negedge core_rst_n)
  begin
    if (!core_rst_n)
      gain_q <= `ZERO_BYTE;
    else if (wr_gain)
      gain_q <= req.wdata & `LUMA_GAIN_MASK;
  end

  always_ff @(posedge mclk or negedge core_rst_n)
  begin
    if (!core_rst_n)
      scaler_q <= `ZERO_BYTE;
    else if (wr_scaler)
      scaler_q <= req.wdata & `SCALER_MASK;
  end

  always_ff @(posedge mclk or negedge core_rst_n)
  begin
    if (!core_rst_n)
      feature_q <= `ZERO_BYTE;
    else if (wr_feature)
      feature_q <= req.wdata & `FEATURE_RW_MASK;
  end

  always_ff @(posedge mclk or negedge core_rst_n)
  begin
    if (!core_rst_n)
      oper_q <= `ZERO_BYTE;
    else if (wr_oper)
      oper_q <= req.wdata & `OPER_MASK;
  end

  // A new no-ack event wins over a clear in the same cycle.
  logic no_ack_clr;
  assign no_ack_clr = (wr_status & ~req.wdata[`BIT_NO_ACK]) | sec_cmd_issued;
  always_ff @(posedge mclk or negedge core_rst_n)
  begin
    if (!core_rst_n)
      no_ack_q <= 1'b0;
    else if (clk_en)
    begin
      if (no_ack_event)
        no_ack_q <= 1'b1;
      else if (no_ack_clr)
        no_ack_q <= 1'b0;
    end
  end

  // White balance runs from a start write until the engine reports done.
  always_comb
  begin
    awb_d = awb_q;
    case (awb_q)
      AWB_IDLE:
        if (awb_go)
          awb_d = AWB_RUN;
      AWB_RUN:
        if (awb_done)
          awb_d = AWB_IDLE;
      default:
        awb_d = AWB_IDLE;
    endcase
  end
  always_ff @(posedge mclk or negedge core_rst_n)
  begin
    if (!core_rst_n)
      awb_q <= AWB_IDLE;
    else if (clk_en)
      awb_q <= awb_d;
  end

  // Read path.
  logic [7:0] status_val;
  logic [7:0] feature_val;
  logic [7:0] rd_mux;
  assign status_val = {1'b0, pin_q[3], pin_q[2], pin_q[1],
                       boot_load_active, secondary_master_busy,
                       no_ack_q, pin_q[0]};
  assign feature_val = feature_q | {6'h00, (awb_q == AWB_RUN), 1'b0};
  assign rd_mux =
    (req.addr == `OFS_DEVICE_STATUS) ? status_val :
    (req.addr == `OFS_PIN_IO_CONTROL) ? pin_io_q :
    (req.addr == `OFS_LUMA_GAIN) ? gain_q :
    (req.addr == `OFS_SCALER_CONTROL) ? scaler_q :
    (req.addr == `OFS_FEATURE_CONTROL) ? feature_val :
    (req.addr == `OFS_OPERATIONAL_CONTROL) ? oper_q : `ZERO_BYTE;

  // Next values of the packed controls, in the field order of the package.
  scaler_cfg_s scaler_cfg_d;
  feature_cfg_s feature_cfg_d;
  oper_cfg_s oper_cfg_d;
  logic strap_5to4_d;
  logic outputs_on_d;
  assign scaler_cfg_d = {scaler_q[2:0], scaler_q[3], scaler_q[4],
                         scaler_q[5]};
  assign feature_cfg_d = {feature_q[2], feature_q[3],
                          feature_q[4]};
  assign oper_cfg_d = {oper_q[0], oper_q[1], oper_q[2], oper_q[3],
                       oper_q[4], oper_q[5], oper_q[6]};
  // The strap only matters while the native-mode bit is clear.
  assign strap_5to4_d = ~scaler_q[4] & pin_q[2];
  // An equality rather than a plain enable: either level of the pin works.
  assign outputs_on_d = (oper_q[3] == pin_q[4]);

  // Every output is registered so the datapath sees glitch-free controls.
  always_ff @(posedge mclk or negedge srst_n)
  begin
    if (!srst_n)
      rdata_valid <= 1'b0;
    else if (clk_en)
      rdata_valid <= req.rd;
  end

  // Read data holds between reads so a slow controller may fetch it late.
  always_ff @(posedge mclk or negedge srst_n)
  begin
    if (!srst_n)
      rdata <= `ZERO_BYTE;
    else if (clk_en && req.rd)
      rdata <= rd_mux;
  end

  always_ff @(posedge mclk or negedge srst_n)
  begin
    if (!srst_n)
      soft_reset_pulse <= 1'b0;
    else if (clk_en)
      soft_reset_pulse <= soft_rst_q;
  end

  always_ff @(posedge mclk or negedge srst_n)
  begin
    if (!srst_n)
      awb_start_pulse <= 1'b0;
    else if (clk_en)
      awb_start_pulse <= (awb_q == AWB_IDLE) & awb_go;
  end

  always_ff @(posedge mclk or negedge srst_n)
  begin
    if (!srst_n)
      pll_clock_out_enable <= 1'b0;
    else if (clk_en)
      pll_clock_out_enable <= pin_io_q[0];
  end

  always_ff @(posedge mclk or negedge srst_n)
  begin
    if (!srst_n)
      field_pin_direction <= 1'b0;
    else if (clk_en)
      field_pin_direction <= pin_io_q[1];
  end

  always_ff @(posedge mclk or negedge srst_n)
  begin
    if (!srst_n)
      chroma_phase_clock_select <= 1'b0;
    else if (clk_en)
      chroma_phase_clock_select <= pin_io_q[2];
  end

  always_ff @(posedge mclk or negedge srst_n)
  begin
    if (!srst_n)
      luma_gain_value <= 5'h00;
    else if (clk_en)
      luma_gain_value <= gain_q[4:0];
  end

  always_ff @(posedge mclk or negedge srst_n)
  begin
    if (!srst_n)
      scaler_cfg <= '0;
    else if (clk_en)
      scaler_cfg <= scaler_cfg_d;
  end

  always_ff @(posedge mclk or negedge srst_n)
  begin
    if (!srst_n)
      scaler_5to4_select <= 1'b0;
    else if (clk_en)
      scaler_5to4_select <= strap_5to4_d;
  end

  always_ff @(posedge mclk or negedge srst_n)
  begin
    if (!srst_n)
      feature_cfg <= '0;
    else if (clk_en)
      feature_cfg <= feature_cfg_d;
  end

  always_ff @(posedge mclk or negedge srst_n)
  begin
    if (!srst_n)
      oper_cfg <= '0;
    else if (clk_en)
      oper_cfg <= oper_cfg_d;
  end

  always_ff @(posedge mclk or negedge srst_n)
  begin
    if (!srst_n)
      digital_outputs_enable <= 1'b0;
    else if (clk_en)
      digital_outputs_enable <= outputs_on_d;
  end
endmodule : vproc_control_regs
`default_nettype wire

/* shared/vproc_regs_cfg.svh */
// Register offsets, field positions and reset values of the control bank.
`ifndef VPROC_REGS_CFG_SVH
`define VPROC_REGS_CFG_SVH
`define OFS_MASTER_RESET 8'h00
`define OFS_DEVICE_STATUS 8'h01
`define OFS_PIN_IO_CONTROL 8'h02
`define OFS_LUMA_GAIN 8'h03
`define OFS_SCALER_CONTROL 8'h04
`define OFS_FEATURE_CONTROL 8'h05
`define OFS_OPERATIONAL_CONTROL 8'h06
`define BIT_FULL_RESET 0
`define BIT_EVEN_FIELD 0
`define BIT_NO_ACK 1
`define BIT_SEC_BUSY 2
`define BIT_BOOT_ACTIVE 3
`define BIT_HIZ_STRAP 4
`define BIT_SCALER_STRAP 5
`define BIT_FOUR_BYTE_STRAP 6
`define BIT_AWB_START 1
`define PIN_IO_MASK 8'h07
`define LUMA_GAIN_MASK 8'h1F
`define SCALER_MASK 8'h3F
`define FEATURE_RW_MASK 8'h1C
`define OPER_MASK 8'h7F
`define ZERO_BYTE 8'h00
`endif

/* shared/vproc_regs_pkg.sv */
// Types shared by the control register bank.
`default_nettype none
package vproc_regs_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic [2:0] mode;
    logic custom;
    logic native;
    logic pal_timing_select;
  } scaler_cfg_s;

  typedef struct packed {
    logic gamma_lut_enable;
    logic luma_peaking_disable;
    logic chroma_lowpass_disable;
  } feature_cfg_s;

  typedef struct packed {
    logic odd_first_line_blue;
    logic even_first_line_blue;
    logic first_pixel_positive;
    logic oe_bit;
    logic external_reference_select;
    logic parallel_output_select;
    logic vsync_output_select;
  } oper_cfg_s;

  typedef enum logic [1:0] {
    AWB_IDLE = 2'b00,
    AWB_RUN = 2'b01
  } awb_state_e;
endpackage : vproc_regs_pkg
`default_nettype wire

/* tb/vproc_regs_chk_assertions.sv */
// Checker on the ports of the control register bank.
`timescale 1ns/1ps
`default_nettype none
module vproc_regs_chk
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Requests.
  input wire vproc_regs_pkg::reg_req_s req,
  input wire logic boot_load_active,
  // Results.
  input wire logic [7:0] rdata,
  input wire logic pll_clock_out_enable,
  input wire logic [4:0] luma_gain_value,
  input wire vproc_regs_pkg::scaler_cfg_s scaler_cfg,
  input wire vproc_regs_pkg::oper_cfg_s oper_cfg
);
  import vproc_regs_pkg::*;
  wire logic w;
  wire logic [7:0] d;
  wire logic [5:0] sd;
  wire logic [6:0] od;
  // A write only lands on an enabled edge outside the boot download.
  assign w = clk_en & req.wr & ~boot_load_active;
  assign d = req.wdata;
  assign sd = {d[2:0], d[3], d[4], d[5]};
  assign od = {d[0], d[1], d[2], d[3], d[4], d[5], d[6]};
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  pll_follow_a: assert property (w && req.addr == 8'h02 |-> ##2
    {7'h00, pll_clock_out_enable} == ($past(d, 2) & 8'h01))
    else $error("pll enable mismatch");
  gain_follow_a: assert property (w && req.addr == 8'h03 |-> ##2
    {3'h0, luma_gain_value} == ($past(d, 2) & 8'h1F))
    else $error("luma gain mismatch");
  scaler_follow_a: assert property (w && req.addr == 8'h04 |-> ##2
    scaler_cfg == $past(sd, 2)) else $error("scaler config mismatch");
  oper_follow_a: assert property (w && req.addr == 8'h06 |-> ##2
    oper_cfg == $past(od, 2)) else $error("operational config mismatch");
  boot_refuse_a: assert property (req.wr && boot_load_active &&
    req.addr == 8'h03 |-> ##2 $stable(luma_gain_value))
    else $error("write taken during boot load");
  boot_flag_a: assert property (req.rd && req.addr == 8'h01 |=>
    rdata[3] == $past(boot_load_active)) else $error("boot flag wrong");
  status_reserved_a: assert property (req.rd && req.addr == 8'h01 |=>
    !rdata[7]) else $error("reserved status bit set");
  soft_clear_a: assert property (w && req.addr == 8'h00 && d[0] |->
    ##[2:4] luma_gain_value == 5'h00 && !pll_clock_out_enable)
    else $error("soft reset did not clear");
endmodule : vproc_regs_chk
`default_nettype wire

/* tb/vproc_host_model.sv */
// Model of the external controller on the primary control port.
`timescale 1ns/1ps
`default_nettype none
module vproc_host_model
(
  // Clock.
  input wire logic mclk,
  // Register access toward the bank.
  output var vproc_regs_pkg::reg_req_s req,
  input wire logic [7:0] rdata,
  input wire logic rdata_valid
);
  import vproc_regs_pkg::*;
  initial req = '0;
  task xfer(input logic w, input logic r, input logic [7:0] a,
    input logic [7:0] d);
    req <= '{w, r, a, d};
    @(posedge mclk);
  endtask : xfer
  // Address and data wander while idle, so stale values prove nothing.
  task idle();
    xfer(1'b0, 1'b0, 8'($urandom), 8'($urandom));
  endtask : idle
  task wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, 1'b0, a, d);
    idle();
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    xfer(1'b0, 1'b1, a, 8'h00);
    req <= '{1'b0, 1'b0, 8'($urandom), 8'($urandom)};
    @(negedge mclk);
    d = rdata;
    v = rdata_valid;
    @(posedge mclk);
  endtask : rd
  task init();
    for (int i = 'h23; i <= 'h26; i++)
      wr(8'(i), 8'hFF);
  endtask : init
endmodule : vproc_host_model
`default_nettype wire

/* tb/video_processor_control_regs_test.sv */
// Self-checking bench for the control register bank.
`timescale 1ns/1ps
`default_nettype none
module video_processor_control_regs_test;
  import vproc_regs_pkg::*;
  logic mclk, rst_n, clk_en, rdata_valid, srp, pll, fdir, uvc, s54, awbp, doe;
  logic [4:0] ev, pins, gain;
  logic [7:0] rdata, d;
  logic v;
  reg_req_s req;
  scaler_cfg_s scfg;
  feature_cfg_s fcfg;
  oper_cfg_s ocfg;
  int miscompares, n_compared, x;
  int mdl[9];
  int msk[9] = '{'h00, 'h00, 'h07, 'h1F, 'h3F, 'h1C, 'h7F, 'h00, 'h00};
  vproc_host_model u_host
  (
    .mclk(mclk), .req(req), .rdata(rdata), .rdata_valid(rdata_valid)
  );
  vproc_control_regs u_dut
  (
    .mclk(mclk), .clk_en(clk_en), .rst_n(rst_n), .req(req), .rdata(rdata),
    .rdata_valid(rdata_valid), .no_ack_event(ev[0]),
    .sec_cmd_issued(ev[1]), .secondary_master_busy(ev[2]),
    .boot_load_active(ev[3]), .awb_done(ev[4]), .even_field_pin(pins[0]),
    .hiz_strap_pin(pins[1]), .scaler_strap_pin(pins[2]),
    .four_byte_strap_pin(pins[3]), .output_enable_pin(pins[4]),
    .soft_reset_pulse(srp), .pll_clock_out_enable(pll),
    .field_pin_direction(fdir), .chroma_phase_clock_select(uvc),
    .luma_gain_value(gain), .scaler_cfg(scfg), .scaler_5to4_select(s54),
    .awb_start_pulse(awbp), .feature_cfg(fcfg), .oper_cfg(ocfg),
    .digital_outputs_enable(doe)
  );
  function automatic logic [7:0] obs(input int a);
    case (a)
      2: obs = {5'h00, uvc, fdir, pll};
      3: obs = {3'h0, gain};
      4: obs = {2'h0, scfg[0], scfg[1], scfg[2], scfg[5:3]};
      5: obs = {3'h0, fcfg[0], fcfg[1], fcfg[2], 2'h0};
      default: obs = {1'b0, ocfg[0], ocfg[1], ocfg[2], ocfg[3], ocfg[4],
        ocfg[5], ocfg[6]};
    endcase
  endfunction : obs
  task check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task final_report();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report
  task sweep();
    for (int a = 0; a < 9; a++)
    begin
      u_host.rd(8'(a), d, v);
      check("valid", {7'h00, v}, 8'h01);
      check("rdata", d, 8'(mdl[a] & msk[a]));
      if (a > 1 && a < 7)
        check("config", obs(a), 8'(mdl[a] & msk[a]));
    end
  endtask : sweep
  // Counts a one-cycle strobe over a short window that spans the write.
  task automatic pulses(ref logic s, input logic [7:0] a,
    input logic [7:0] b);
    x = 0;
    fork
      u_host.wr(a, b);
      repeat (4)
      begin
        @(negedge mclk);
        x += int'(s === 1'b1);
      end
    join
    @(posedge mclk);
  endtask : pulses
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial
  begin
    {rst_n, clk_en, ev, pins} = {2'b01, 10'h000};
    {miscompares, n_compared} = 0;
    x = $urandom(17711);
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    u_host.init();
    for (int a = 2; a < 7; a++)
    begin
      mdl[a] = $urandom & ((a == 5) ? 'hFD : 'hFF);
      u_host.wr(8'(a), 8'(mdl[a]));
    end
    sweep();
    pins <= 5'($urandom);
    ev <= 5'b01100;
    repeat (6) @(posedge mclk);
    u_host.wr(8'h03, 8'(~mdl[3]));
    u_host.rd(8'h01, d, v);
    check("status", d, {1'b0, pins[3:1], 3'b110, pins[0]});
    u_host.rd(8'h03, d, v);
    check("refused", d, 8'(mdl[3] & 'h1F));
    check("strap", {7'h00, s54}, {7'h00, ~mdl[4][4] & pins[2]});
    ev <= 5'b00000;
    repeat (2)
    begin
      pins[4] <= ~pins[4];
      repeat (6) @(posedge mclk);
      check("oe", {7'h00, doe}, {7'h00, mdl[6][3] == pins[4]});
    end
    pins <= 5'h00;
    repeat (5) @(posedge mclk);
    ev <= 5'b00001;
    @(posedge mclk);
    ev <= 5'b00000;
    u_host.wr(8'h01, 8'hFF);
    u_host.rd(8'h01, d, v);
    check("no_ack", d, 8'h02);
    u_host.wr(8'h01, 8'h00);
    u_host.rd(8'h01, d, v);
    check("no_ack_clr", d, 8'h00);
    ev <= 5'b00001;
    @(posedge mclk);
    ev <= 5'b00010;
    @(posedge mclk);
    ev <= 5'b00000;
    u_host.rd(8'h01, d, v);
    check("no_ack_cmd", d, 8'h00);
    pulses(awbp, 8'h05, 8'(mdl[5] | 'h02));
    check("awb_pulse", 8'(x), 8'h01);
    u_host.wr(8'h05, 8'(mdl[5]));
    u_host.rd(8'h05, d, v);
    check("awb_run", d, 8'((mdl[5] & 'h1C) | 'h02));
    ev <= 5'b10000;
    @(posedge mclk);
    ev <= 5'b00000;
    u_host.rd(8'h05, d, v);
    check("awb_done", d, 8'(mdl[5] & 'h1C));
    clk_en <= 1'b0;
    u_host.wr(8'h03, 8'(~mdl[3]));
    clk_en <= 1'b1;
    u_host.rd(8'h03, d, v);
    check("frozen", d, 8'(mdl[3] & 'h1F));
    pulses(srp, 8'h00, 8'h01);
    check("soft_pulse", 8'(x), 8'h01);
    mdl = '{default: 0};
    sweep();
    final_report();
  end
endmodule : video_processor_control_regs_test
bind vproc_control_regs vproc_regs_chk u_chk
(
  .mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .req(req), .rdata(rdata),
  .boot_load_active(boot_load_active), .luma_gain_value(luma_gain_value),
  .pll_clock_out_enable(pll_clock_out_enable), .scaler_cfg(scaler_cfg),
  .oper_cfg(oper_cfg)
);
`default_nettype wire
